// ==== core/pxb_consts.svh ====
`ifndef PXB_CONSTS_SVH
`define PXB_CONSTS_SVH
// byte addresses of the port and crossbar registers
`define PXB_ADDR_PORT0   8'h80
`define PXB_ADDR_PORT1   8'h90
`define PXB_ADDR_PORT2   8'hA0
`define PXB_ADDR_PORT3   8'hB0
`define PXB_ADDR_XBAR3   8'hE3
// reset values
`define PXB_PORT_RST     8'hFF
`define PXB_XBAR3_RST    8'h00
// field positions in the third crossbar register
`define PXB_BIT_PUD      3'd7
`define PXB_BIT_XBAR_EN  3'd6
`define PXB_BIT_CNVST    3'd0
`define PXB_XBAR3_MASK   8'hC1
`endif

// ==== core/pxb_pkg.sv ====
package pxb_pkg;
    // one special-function register access from the core
    typedef struct packed {
        logic       rd;      // read strobe
        logic       wr;      // write strobe
        logic       rmw;     // read-modify-write read (latch, not pin)
        logic       bit_op;  // single-bit access
        logic [2:0] bit_sel; // selected bit
        logic [7:0] addr;    // sfr address
        logic [7:0] wdata;   // write data (bit_op uses wdata[0])
    } pxb_sfr_req_s;
    typedef logic [3:0][7:0] pxb_ports_t;
endpackage

// ==== core/pxb_port_io.sv ====
`timescale 1ns/100ps
// Behaviour
// - four independent eight-bit general-purpose ports
// - byte and single-bit register access supported
// - writes update persistent output latch
// - plain reads return sampled pin levels
// - read-modify-write reads the output latch
// - bit move/clear/set also uses latch
// - unbonded ports still work for software
// - pull-ups enabled after reset, register zero
`include "pxb_consts.svh"
module pxb_port_io
    import pxb_pkg::*;
(
    input  wire logic         i_core_clk,     // system clock
    input  wire logic         i_rstn,         // async reset, active low
    input  wire pxb_sfr_req_s i_sfr,          // sfr access
    output logic [7:0]        o_rdata,        // read data, registered
    output logic              o_hit,          // address matched, registered
    input  wire pxb_ports_t   i_pin,          // pin levels
    input  wire pxb_ports_t   i_out_cfg,      // 1 = push-pull per pin
    input  wire pxb_ports_t   i_periph_en,    // crossbar-owned pins
    input  wire pxb_ports_t   i_periph_out,   // peripheral output value
    output pxb_ports_t        o_pin_out,      // pin output value
    output pxb_ports_t        o_pin_oe,       // pin driven
    output logic              o_pullup_en,    // weak pull-ups on
    output logic              o_xbar_en,      // crossbar enabled
    output logic              o_cnvst_route   // conversion start routed
);
    logic       rst_meta_reg;
    logic       rst_n_reg;
    pxb_ports_t latch_reg;
    logic [7:0] xbar3_reg;
    logic [7:0] xbar3_mask;
    logic [1:0] sel;
    logic       port_hit;

    ////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // address decode for the four port registers
    always_comb
    begin
        port_hit = 1'b1;
        sel      = 2'd0;
        if (i_sfr.addr == `PXB_ADDR_PORT0)
            sel = 2'd0;
        else if (i_sfr.addr == `PXB_ADDR_PORT1)
            sel = 2'd1;
        else if (i_sfr.addr == `PXB_ADDR_PORT2)
            sel = 2'd2;
        else if (i_sfr.addr == `PXB_ADDR_PORT3)
            sel = 2'd3;
        else
            port_hit = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // output latches; unbonded ports keep full latches too
    generate
        for (genvar p = 0; p < 4; p++)
        begin : g_port
            always_ff @(posedge i_core_clk or negedge rst_n_reg)
            begin
                if (!rst_n_reg)
                    latch_reg[p] <= `PXB_PORT_RST;
                else if (i_sfr.wr && port_hit && sel == 2'(p))
                begin
                    if (i_sfr.bit_op)
                        latch_reg[p][i_sfr.bit_sel] <= i_sfr.wdata[0];
                    else
                        latch_reg[p] <= i_sfr.wdata;
                end
            end
            // 0 drives low; 1 drives high only in push-pull
            // crossbar-owned pins take the peripheral value while o_xbar_en is set
            for (genvar b = 0; b < 8; b++)
            begin : g_bit
                logic v;
                assign v = (o_xbar_en && i_periph_en[p][b]) ?
                           i_periph_out[p][b] : latch_reg[p][b];
                assign o_pin_out[p][b] = v;
                assign o_pin_oe[p][b]  = !v || i_out_cfg[p][b];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // only pull-up, crossbar and conversion-start bits are writable
    assign xbar3_mask = `PXB_XBAR3_MASK;

    // third crossbar control register; zero reset enables pull-ups
    always_ff @(posedge i_core_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            xbar3_reg <= `PXB_XBAR3_RST;
        else if (i_sfr.wr && i_sfr.addr == `PXB_ADDR_XBAR3)
        begin
            if (i_sfr.bit_op)
                xbar3_reg[i_sfr.bit_sel] <= i_sfr.wdata[0]
                    & xbar3_mask[i_sfr.bit_sel];
            else
                xbar3_reg <= i_sfr.wdata & `PXB_XBAR3_MASK;
        end
    end

    assign o_pullup_en   = !xbar3_reg[`PXB_BIT_PUD];
    assign o_xbar_en     = xbar3_reg[`PXB_BIT_XBAR_EN];
    assign o_cnvst_route = xbar3_reg[`PXB_BIT_CNVST];

    ////////////////////////////////////////////////////////////////////
    // read path: pins normally, latch for rmw; unmapped reads zero
    always_ff @(posedge i_core_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            o_rdata <= 8'h00;
            o_hit   <= 1'b0;
        end
        else if (i_sfr.rd && port_hit)
        begin
            o_hit <= 1'b1;
            if (i_sfr.rmw)
                o_rdata <= latch_reg[sel];
            else
                o_rdata <= i_pin[sel];
        end
        else if (i_sfr.rd && i_sfr.addr == `PXB_ADDR_XBAR3)
        begin
            o_hit   <= 1'b1;
            o_rdata <= xbar3_reg;
        end
        else
        begin
            o_hit   <= 1'b0;
            o_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_rmw_latch;
        @(posedge i_core_clk) disable iff (!rst_n_reg)
        (i_sfr.rd && i_sfr.rmw && i_sfr.addr == `PXB_ADDR_PORT0
         && !i_sfr.wr) |=> (o_rdata == $past(latch_reg[0]));
    endproperty
    a_rmw_latch: assert property (p_rmw_latch)
        else $error("rmw read did not return latch");

    property p_pin_read;
        @(posedge i_core_clk) disable iff (!rst_n_reg)
        (i_sfr.rd && !i_sfr.rmw && i_sfr.addr == `PXB_ADDR_PORT1)
        |=> (o_rdata == $past(i_pin[1]) && o_hit);
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("plain read did not return pins");

    property p_byte_write;
        @(posedge i_core_clk) disable iff (!rst_n_reg)
        (i_sfr.wr && !i_sfr.bit_op && i_sfr.addr == `PXB_ADDR_PORT2)
        |=> (latch_reg[2] == $past(i_sfr.wdata));
    endproperty
    a_byte_write: assert property (p_byte_write)
        else $error("byte write not latched");

    property p_bit_write;
        @(posedge i_core_clk) disable iff (!rst_n_reg)
        (i_sfr.wr && i_sfr.bit_op && i_sfr.addr == `PXB_ADDR_PORT3)
        |=> ((latch_reg[3] >> $past(i_sfr.bit_sel)) & 8'h01)
             == {7'h00, $past(i_sfr.wdata[0])}
            && ((latch_reg[3] ^ $past(latch_reg[3]))
             & ~(8'h01 << $past(i_sfr.bit_sel))) == 8'h00;
    endproperty
    a_bit_write: assert property (p_bit_write)
        else $error("bit write disturbed other bits");

    property p_low_drives;
        @(posedge i_core_clk) disable iff (!rst_n_reg)
        (!o_xbar_en && !latch_reg[0][0]) |-> o_pin_oe[0][0];
    endproperty
    a_low_drives: assert property (p_low_drives)
        else $error("latch low not driven");

    property p_pullup_reset;
        @(posedge i_core_clk)
        $rose(rst_n_reg) |-> o_pullup_en && !o_xbar_en;
    endproperty
    a_pullup_reset: assert property (p_pullup_reset)
        else $error("pull-ups not enabled after reset");

    property p_xbar_route;
        @(posedge i_core_clk) disable iff (!rst_n_reg)
        o_xbar_en |-> ((o_pin_out[0] ^ i_periph_out[0])
                       & i_periph_en[0]) == 8'h00;
    endproperty
    a_xbar_route: assert property (p_xbar_route)
        else $error("crossbar pin not given peripheral value");

    property p_gpio_keep;
        @(posedge i_core_clk) disable iff (!rst_n_reg)
        1'b1 |-> ((o_pin_out[0] ^ latch_reg[0])
                  & ~(i_periph_en[0] & {8{o_xbar_en}})) == 8'h00;
    endproperty
    a_gpio_keep: assert property (p_gpio_keep)
        else $error("unassigned pin lost its latch value");

    property p_open_drain;
        @(posedge i_core_clk) disable iff (!rst_n_reg)
        (latch_reg[1][0] && !i_out_cfg[1][0]
         && !(o_xbar_en && i_periph_en[1][0])) |-> !o_pin_oe[1][0];
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain one still driven");
endmodule

// ==== tb/pxb_pin_model.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// board side: a released pin shows what the board puts on it
module pxb_pin_model
    import pxb_pkg::*;
(
    input  wire pxb_ports_t i_out, // device pin value
    input  wire pxb_ports_t i_oe,  // device drives pin
    input  wire pxb_ports_t i_ext, // board level on released pins
    output pxb_ports_t      o_pin  // resolved pin level
);
    // board level wins only where the device lets go, so open drain shows
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`include "pxb_consts.svh"
module tb;
    import pxb_pkg::*;
    logic         i_core_clk;
    logic         i_rstn;
    pxb_sfr_req_s sfr;
    logic [7:0]   rdata;
    logic         hit, pu, xe, cr;
    pxb_ports_t   pin, cfg, pout, poe, ext, pen, pval;
    int           err_total, checked, cyc;
    pxb_port_io DUT (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_sfr(sfr),
        .o_rdata(rdata), .o_hit(hit), .i_pin(pin), .i_out_cfg(cfg),
        .i_periph_en(pen), .i_periph_out(pval), .o_pin_out(pout),
        .o_pin_oe(poe), .o_pullup_en(pu), .o_xbar_en(xe),
        .o_cnvst_route(cr));
    pxb_pin_model board (.i_out(pout), .i_oe(poe), .i_ext(ext), .o_pin(pin));
    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        i_core_clk = 0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input string n, input logic [7:0] s, e);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // one access; request held for exactly one taking edge
    task automatic acc(input logic r, w, m, b, input logic [2:0] bs,
                       input logic [7:0] a, d);
        @(posedge i_core_clk);
        sfr <= '{r, w, m, b, bs, a, d};
        @(posedge i_core_clk);
        sfr <= '0;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        acc(1, 0, 1, 0, 0, `PXB_ADDR_PORT0, 0);
        chk("latch0", rdata, `PXB_PORT_RST);
        chk("hit", {7'h0, hit}, 8'h01);
        acc(1, 0, 0, 0, 0, `PXB_ADDR_XBAR3, 0);
        chk("xbar3", rdata, `PXB_XBAR3_RST);
        chk("pullup", {7'h0, pu}, 8'h01);
        $display("reset test done");
    endtask
    task automatic t_ports;
        for (int p = 0; p < 4; p++)
        begin
            acc(0, 1, 0, 0, 0, 8'h80 + 8'(p << 4), 8'h3C ^ 8'(p));
            acc(1, 0, 0, 0, 0, 8'h80 + 8'(p << 4), 0);
            chk("pins", rdata, 8'h3C ^ 8'(p));
            chk("pinout", pout[p], 8'h3C ^ 8'(p));
        end
        $display("port test done");
    endtask
    // open drain: ones float to board low, so pins and latch differ
    task automatic t_rmw;
        @(posedge i_core_clk);
        cfg <= '0;
        acc(0, 1, 0, 0, 0, `PXB_ADDR_PORT1, 8'hA5);
        acc(1, 0, 0, 0, 0, `PXB_ADDR_PORT1, 0);
        chk("p1 pins", rdata, 8'h00);
        chk("p1 oe", poe[1], 8'h5A);
        acc(1, 0, 1, 0, 0, `PXB_ADDR_PORT1, 0);
        chk("p1 latch", rdata, 8'hA5);
        acc(0, 1, 0, 0, 0, `PXB_ADDR_PORT2, 8'hFF);
        acc(0, 1, 0, 1, 3, `PXB_ADDR_PORT2, 0);
        acc(1, 0, 1, 0, 0, `PXB_ADDR_PORT2, 0);
        chk("p2 bit", rdata, 8'hF7);
        acc(0, 1, 0, 1, 6, `PXB_ADDR_PORT3, 1);
        acc(1, 0, 1, 0, 0, `PXB_ADDR_PORT3, 0);
        chk("p3 bit", rdata, 8'h7F);
        $display("rmw test done");
    endtask
    task automatic t_xbar;
        acc(0, 1, 0, 0, 0, `PXB_ADDR_XBAR3, 8'hFF);
        acc(1, 0, 0, 0, 0, `PXB_ADDR_XBAR3, 0);
        chk("xbar3", rdata, `PXB_XBAR3_MASK);
        chk("ctl", {5'h0, pu, xe, cr}, 8'h03);
        // two low pins of port 0 handed to a peripheral, board pulls high
        @(posedge i_core_clk);
        pen[0] <= 8'h03;
        pval[0] <= 8'h02;
        ext[0] <= 8'hFF;
        acc(1, 0, 0, 0, 0, `PXB_ADDR_PORT0, 0);
        chk("xbar pins", rdata, 8'h3E);
        chk("xbar out", pout[0], 8'h3E);
        acc(1, 0, 1, 0, 0, `PXB_ADDR_PORT0, 0);
        chk("xbar latch", rdata, 8'h3C);
        acc(1, 0, 0, 0, 0, 8'h81, 0);
        chk("unmapped", {hit, rdata[6:0]}, 8'h00);
        $display("crossbar test done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // all ports start push-pull and board low on released pins
    initial
    begin
        {err_total, checked, cyc} = '0;
        i_rstn = 0;
        sfr = '0;
        cfg = '1;
        ext = '0;
        {pen, pval} = '0;
        repeat (16) @(posedge i_core_clk);
        i_rstn <= 1;
        repeat (3) @(posedge i_core_clk);
        t_reset();
        t_ports();
        t_rmw();
        t_xbar();
        summarize();
    end
endmodule
